// ==== design/psr_dev.sv ====
// Purpose: sensor end of the serial command and readout link
// Assumes: serial logic runs on the link clock, conversion timing on MCLK
// Notes: dout mixes a link-domain data bit with a cross-domain busy flag

`timescale 1ns/10ps

// Behaviour
// R1: sample din and launch dout on rise
// R2: host samples and changes on falling edge
// R3: host generates the serial clock
// R4: framing purely by din bit patterns
// R5: three high bits start each command
// R6: three low bits stop each command
// R7: four setup bits pick the operation
// R8: five instructions decoded; the code decodes six setup codes
// R9: dout rises on last stop bit
// R10: host gives two clocks after acknowledge
// R11: dout falls when conversion ends
// R12: seventeen clocks read sixteen-bit result
// R13: stalled clock keeps the read position
// R14: host reads result before next conversion
// R15: dout carries result, calibration or status
// R16: pressure and temperature share one converter
// R17: sixty-four calibration bits, four words
// R18: six coefficients packed into four words
// R19: bridge powered only briefly per conversion
// R20: twenty-one bit pattern restarts protocol
// R21: host sends reset pattern first
// R22: words and setup bits go msb first
module psr_dev #(
  parameter int CONV_CYC = psr_pkg::CONV_CYCLES,
  parameter int BRIDGE_CYC = psr_pkg::BRIDGE_CYCLES
) (
  // clock, reset, enable
  input logic MCLK,
  input logic RST_B,
  input logic CE,
  // serial link
  psr_link_if.dev LINK,
  // converter samples
  input logic [psr_pkg::WORD_W-1:0] PRESSURE_RAW,
  input logic [psr_pkg::WORD_W-1:0] TEMPERATURE_RAW,
  // factory coefficients
  input logic [psr_pkg::COEF_ONE_W-1:0] COEF_ONE,
  input logic [psr_pkg::COEF_TWO_W-1:0] COEF_TWO,
  input logic [psr_pkg::COEF_THREE_W-1:0] COEF_THREE,
  input logic [psr_pkg::COEF_FOUR_W-1:0] COEF_FOUR,
  input logic [psr_pkg::COEF_FIVE_W-1:0] COEF_FIVE,
  input logic [psr_pkg::COEF_SIX_W-1:0] COEF_SIX,
  // analogue front-end control
  output logic BRIDGE_EN,
  output logic ADC_TEMP_SEL
);
  import psr_pkg::*;

  localparam int TW = $clog2(CONV_CYC + 1);

  // ==========================================================
  // link-domain state
  psr_dev_st_e st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [SETUP_LEN-1:0] setup_q;
  psr_cmd_e sel_q;
  logic [WORD_W-1:0] sh_q;
  logic dout_q;
  logic wait_q;
  logic req_t_q;
  logic conv_temp_q;
  logic [RESET_LEN-1:0] rst_sh_q;
  logic rst_hit;
  psr_cmd_e dec_cmd;
  logic [WORD_W-1:0] word;

  // ==========================================================
  // master-clock-domain state
  logic req_s1_q;
  logic req_s2_q;
  logic done_t_q;
  logic busy_q;
  logic [TW-1:0] tmr_q;
  logic [WORD_W-1:0] result_q;

  // ==========================================================
  // calibration word packing
  logic [WORD_W-1:0] cal_one;
  logic [WORD_W-1:0] cal_two;
  logic [WORD_W-1:0] cal_three;
  logic [WORD_W-1:0] cal_four;

  assign cal_one = {COEF_THREE[LO8_W-1:0], COEF_FIVE[LO8_W-1:0]}; // [R17] [R18]
  assign cal_two = {COEF_FOUR[LO8_W-1:0], COEF_SIX}; // [R18]
  assign cal_three = {COEF_FIVE[COEF_FIVE_W-1:LO8_W], COEF_ONE[COEF_ONE_LO_W-1:0]}; // [R18]
  assign cal_four = {COEF_ONE[COEF_ONE_W-1], COEF_FOUR[COEF_FOUR_W-1], COEF_THREE[COEF_THREE_W-1], COEF_TWO}; // [R18]

  // result words are static once the conversion flag has settled
  always_comb begin
    word = result_q;
    unique case (sel_q)
      CMD_CAL1: word = cal_one;
      CMD_CAL2: word = cal_two;
      CMD_CAL3: word = cal_three;
      CMD_CAL4: word = cal_four;
      default: word = result_q; // [R15] [R16]
    endcase
  end

  assign dec_cmd = psr_setup_to_cmd(setup_q);

  // ==========================================================
  // reset pattern watcher, runs in every protocol state
  assign rst_hit = ({rst_sh_q[RESET_LEN-2:0], LINK.din} == RESET_PATTERN); // [R20]

  always_ff @(posedge LINK.sclk or negedge RST_B) begin
    if (!RST_B) begin
      rst_sh_q <= '0;
    end else if (CE) begin
      rst_sh_q <= {rst_sh_q[RESET_LEN-2:0], LINK.din}; // [R20]
    end
  end

  // ==========================================================
  // command parser and readout shifter
  always_ff @(posedge LINK.sclk or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= D_IDLE;
      cnt_q <= '0;
      setup_q <= '0;
      sel_q <= CMD_PRESS;
      sh_q <= '0;
      dout_q <= 1'b0;
      wait_q <= 1'b0;
      req_t_q <= 1'b0;
      conv_temp_q <= 1'b0;
    end else if (CE) begin
      if (rst_hit) begin
        st_q <= D_IDLE; // [R20]
        cnt_q <= '0;
        dout_q <= 1'b0;
        wait_q <= 1'b0;
      end else begin
        unique case (st_q)
          D_IDLE: begin
            // a run of ones opens a frame, no select line needed
            if (LINK.din) begin // [R1] [R4]
              if (cnt_q == CNT_W'(START_LEN - 1)) begin
                st_q <= D_SETUP; // [R5]
                cnt_q <= '0;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end else begin
              cnt_q <= '0;
            end
          end
          D_SETUP: begin
            setup_q <= {setup_q[SETUP_LEN-2:0], LINK.din}; // [R7] [R22]
            if (cnt_q == CNT_W'(SETUP_LEN - 1)) begin
              st_q <= D_STOP;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          D_STOP: begin
            // a high stop bit means the frame was garbled: drop it
            if (LINK.din) begin // [R6]
              st_q <= D_IDLE;
              cnt_q <= '0;
            end else if (cnt_q == CNT_W'(STOP_LEN - 1)) begin
              cnt_q <= '0;
              sel_q <= dec_cmd; // [R8]
              if (psr_is_conv(dec_cmd)) begin
                st_q <= D_WAIT;
                dout_q <= 1'b1; // [R9]
                wait_q <= 1'b1;
                req_t_q <= ~req_t_q;
                conv_temp_q <= (dec_cmd == CMD_TEMP); // [R16]
              end else if (dec_cmd != CMD_RESET) begin
                st_q <= D_READ; // [R8]
              end else begin
                st_q <= D_IDLE;
              end
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          D_WAIT: begin
            if (cnt_q == CNT_W'(EXTRA_CLKS - 1)) begin // [R10]
              st_q <= D_READ;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          D_READ: begin
            // position only moves on clock edges, so a held clock pauses it
            if (cnt_q == '0) begin // [R13]
              sh_q <= {word[WORD_W-2:0], 1'b0};
              dout_q <= word[WORD_W-1]; // [R1] [R22]
              wait_q <= 1'b0;
              cnt_q <= cnt_q + 1'b1;
            end else if (cnt_q == CNT_W'(READ_CLKS - 1)) begin // [R12]
              dout_q <= 1'b0;
              st_q <= D_IDLE;
              cnt_q <= '0;
            end else begin
              dout_q <= sh_q[WORD_W-1];
              sh_q <= {sh_q[WORD_W-2:0], 1'b0};
              cnt_q <= cnt_q + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // output line: busy flag while waiting, data bit otherwise
  // the busy term needs no link edge, so the end of conversion shows with the clock held low
  assign LINK.dout = wait_q ? (req_t_q ^ done_t_q) : dout_q; // [R11] [R15]

  // ==========================================================
  // request toggle into the master clock domain
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else if (CE) begin
      req_s1_q <= req_t_q;
      req_s2_q <= req_s1_q;
    end
  end

  // ==========================================================
  // conversion timer, bridge power and shared converter selection
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
      done_t_q <= 1'b0;
      result_q <= '0;
      BRIDGE_EN <= 1'b0;
      ADC_TEMP_SEL <= 1'b0;
    end else if (CE) begin
      if (!busy_q) begin
        if (req_s2_q != done_t_q) begin
          busy_q <= 1'b1;
          tmr_q <= '0;
          BRIDGE_EN <= 1'b1; // [R19]
          ADC_TEMP_SEL <= conv_temp_q; // [R16]
        end
      end else begin
        tmr_q <= tmr_q + 1'b1;
        if (tmr_q == TW'(BRIDGE_CYC - 1)) begin
          BRIDGE_EN <= 1'b0; // [R19]
        end
        if (tmr_q == TW'(CONV_CYC - 1)) begin
          busy_q <= 1'b0;
          BRIDGE_EN <= 1'b0;
          result_q <= ADC_TEMP_SEL ? TEMPERATURE_RAW : PRESSURE_RAW; // [R16]
          done_t_q <= req_s2_q; // [R11]
        end
      end
    end
  end

endmodule

// ==== design/psr_pkg.sv ====
// Purpose: shared constants, types and helpers for the pressure sensor serial link
// Assumes: 20 MHz master clock on both ends
// Notes: setup codes and the reset pattern are fixed here for both ends

package psr_pkg;

  // ==========================================================
  // clocking and timing
  localparam int MCLK_HZ = 20_000_000;
  localparam int CONV_TIME_MS = 35;
  localparam int CONV_CYCLES = CONV_TIME_MS * (MCLK_HZ / 1000);
  localparam int BRIDGE_ON_MS = 2;
  localparam int BRIDGE_CYCLES = BRIDGE_ON_MS * (MCLK_HZ / 1000);
  localparam int SCLK_MAX_KHZ = 500;
  // least half period, so round up
  localparam int SCLK_HALF_CYCLES = (MCLK_HZ + 2 * SCLK_MAX_KHZ * 1000 - 1) / (2 * SCLK_MAX_KHZ * 1000);

  // ==========================================================
  // frame layout
  localparam int WORD_W = 16;
  localparam int START_LEN = 3;
  localparam int SETUP_LEN = 4;
  localparam int STOP_LEN = 3;
  localparam int CMD_LEN = START_LEN + SETUP_LEN + STOP_LEN;
  localparam int EXTRA_CLKS = 2;
  localparam int READ_CLKS = 17;
  localparam int RESET_LEN = 21;
  localparam int CNT_W = 5;
  localparam logic [RESET_LEN-1:0] RESET_PATTERN = 21'h155540;

  // ==========================================================
  // setup codes
  localparam logic [SETUP_LEN-1:0] SETUP_PRESS = 4'hA;
  localparam logic [SETUP_LEN-1:0] SETUP_TEMP = 4'h9;
  localparam logic [SETUP_LEN-1:0] SETUP_CAL1 = 4'h5;
  localparam logic [SETUP_LEN-1:0] SETUP_CAL3 = 4'h6;
  localparam logic [SETUP_LEN-1:0] SETUP_CAL2 = 4'hC;
  localparam logic [SETUP_LEN-1:0] SETUP_CAL4 = 4'hD;

  // ==========================================================
  // calibration field widths
  localparam int COEF_ONE_W = 13;
  localparam int COEF_TWO_W = 13;
  localparam int COEF_THREE_W = 9;
  localparam int COEF_FOUR_W = 9;
  localparam int COEF_FIVE_W = 12;
  localparam int COEF_SIX_W = 8;
  localparam int LO8_W = 8;
  localparam int COEF_ONE_LO_W = 12;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    CMD_PRESS = 3'h0,
    CMD_TEMP = 3'h1,
    CMD_CAL1 = 3'h2,
    CMD_CAL2 = 3'h3,
    CMD_CAL3 = 3'h4,
    CMD_CAL4 = 3'h5,
    CMD_RESET = 3'h6
  } psr_cmd_e;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_SETUP = 5'h02,
    D_STOP = 5'h04,
    D_WAIT = 5'h08,
    D_READ = 5'h10
  } psr_dev_st_e;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SEND = 5'h02,
    H_EXTRA = 5'h04,
    H_WAIT = 5'h08,
    H_READ = 5'h10
  } psr_host_st_e;

  // ==========================================================
  // helpers
  function automatic logic [SETUP_LEN-1:0] psr_cmd_to_setup(input psr_cmd_e c);
    logic [SETUP_LEN-1:0] s;
    s = SETUP_PRESS;
    unique case (c)
      CMD_TEMP: s = SETUP_TEMP;
      CMD_CAL1: s = SETUP_CAL1;
      CMD_CAL2: s = SETUP_CAL2;
      CMD_CAL3: s = SETUP_CAL3;
      CMD_CAL4: s = SETUP_CAL4;
      default: s = SETUP_PRESS;
    endcase
    return s;
  endfunction

  // unknown codes map to CMD_RESET, which the device treats as no command
  function automatic psr_cmd_e psr_setup_to_cmd(input logic [SETUP_LEN-1:0] s);
    psr_cmd_e c;
    c = CMD_RESET;
    if (s == SETUP_PRESS) c = CMD_PRESS;
    else if (s == SETUP_TEMP) c = CMD_TEMP;
    else if (s == SETUP_CAL1) c = CMD_CAL1;
    else if (s == SETUP_CAL2) c = CMD_CAL2;
    else if (s == SETUP_CAL3) c = CMD_CAL3;
    else if (s == SETUP_CAL4) c = CMD_CAL4;
    return c;
  endfunction

  function automatic logic psr_is_conv(input psr_cmd_e c);
    return (c == CMD_PRESS) || (c == CMD_TEMP);
  endfunction

endpackage

// ==== design/psr_link_if.sv ====
// Purpose: three-wire serial link between host and sensor
// Assumes: host drives sclk and din, sensor drives dout
// Notes: no chip select exists on this link

`timescale 1ns/10ps

interface psr_link_if;
  logic sclk;
  logic din;
  logic dout;

  modport dev (
    input sclk,
    input din,
    output dout
  );

  modport host (
    output sclk,
    output din,
    input dout
  );
endinterface

// ==== design/psr_host.sv ====
// Purpose: host end that clocks commands into the sensor and reads words back
// Assumes: serial clock derived from MCLK by a divider of at least 3 per half period
// Notes: a reset pattern is sent on its own after every reset release

`timescale 1ns/10ps

module psr_host #(
  parameter int HALF_DIV = psr_pkg::SCLK_HALF_CYCLES
) (
  // clock, reset, enable
  input logic MCLK,
  input logic RST_B,
  input logic CE,
  // serial link
  psr_link_if.host LINK,
  // command port
  input logic CMD_VALID,
  input psr_pkg::psr_cmd_e CMD,
  output logic CMD_READY,
  // result port
  output logic RES_VALID,
  output logic [psr_pkg::WORD_W-1:0] RES_DATA
);
  import psr_pkg::*;

  localparam int DW = $clog2(HALF_DIV + 1);

  psr_host_st_e st_q;
  psr_cmd_e cmd_q;
  logic [DW-1:0] div_q;
  logic sclk_q;
  logic din_q;
  logic init_q;
  logic [RESET_LEN-1:0] tx_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WORD_W-1:0] rx_q;
  logic dout_s1_q;
  logic dout_s2_q;
  logic running;
  logic tick;
  logic fall;
  psr_cmd_e nxt_cmd;

  assign LINK.sclk = sclk_q; // [R3]
  assign LINK.din = din_q;
  assign running = (st_q == H_SEND) || (st_q == H_EXTRA) || (st_q == H_READ);
  assign tick = running && (div_q == DW'(HALF_DIV - 1));
  assign fall = tick && sclk_q;
  assign nxt_cmd = init_q ? CMD_RESET : CMD;

  // ==========================================================
  // sensor output into the master clock domain
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else if (CE) begin
      dout_s1_q <= LINK.dout;
      dout_s2_q <= dout_s1_q;
    end
  end

  // ==========================================================
  // serial clock divider
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      div_q <= '0;
    end else if (CE) begin
      div_q <= (!running || tick) ? '0 : div_q + 1'b1;
    end
  end

  // ==========================================================
  // frame sequencer
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= H_IDLE;
      cmd_q <= CMD_RESET;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      init_q <= 1'b1;
      tx_q <= '0;
      cnt_q <= '0;
      rx_q <= '0;
      CMD_READY <= 1'b0;
      RES_VALID <= 1'b0;
      RES_DATA <= '0;
    end else if (CE) begin
      RES_VALID <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          CMD_READY <= !init_q;
          if (init_q || (CMD_VALID && CMD_READY)) begin // [R21]
            init_q <= 1'b0;
            CMD_READY <= 1'b0;
            cmd_q <= nxt_cmd;
            st_q <= H_SEND;
            if (nxt_cmd == CMD_RESET) begin
              tx_q <= RESET_PATTERN; // [R20]
              din_q <= RESET_PATTERN[RESET_LEN-1];
              cnt_q <= CNT_W'(RESET_LEN);
            end else begin
              // start, setup, stop; no chip select on this link
              tx_q <= {{START_LEN{1'b1}}, psr_cmd_to_setup(nxt_cmd), {STOP_LEN{1'b0}}, // [R4] [R5] [R6] [R7]
                       {(RESET_LEN - CMD_LEN){1'b0}}};
              din_q <= 1'b1;
              cnt_q <= CNT_W'(CMD_LEN);
            end
          end
        end
        H_SEND, H_EXTRA, H_READ: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (fall) begin
            // data changes and samples on the falling edge, away from the sensor's edge
            sclk_q <= 1'b0; // [R2]
            cnt_q <= cnt_q - 1'b1;
            tx_q <= {tx_q[RESET_LEN-2:0], 1'b0};
            din_q <= tx_q[RESET_LEN-2]; // [R22]
            if ((st_q == H_READ) && (cnt_q != CNT_W'(1))) begin
              rx_q <= {rx_q[WORD_W-2:0], dout_s2_q}; // [R2] [R12]
            end
            if (cnt_q == CNT_W'(1)) begin
              din_q <= 1'b0;
              if (st_q == H_READ) begin
                st_q <= H_IDLE;
                RES_VALID <= 1'b1; // [R14]
                RES_DATA <= rx_q;
              end else if (st_q == H_EXTRA) begin
                st_q <= H_WAIT; // [R11]
              end else if (cmd_q == CMD_RESET) begin
                st_q <= H_IDLE;
              end else if (psr_is_conv(cmd_q)) begin
                st_q <= H_EXTRA; // [R10]
                cnt_q <= CNT_W'(EXTRA_CLKS);
              end else begin
                st_q <= H_READ;
                cnt_q <= CNT_W'(READ_CLKS);
              end
            end
          end
        end
        H_WAIT: begin
          // clock held low until the sensor drops its busy level
          if (!dout_s2_q) begin // [R11]
            st_q <= H_READ;
            cnt_q <= CNT_W'(READ_CLKS); // [R12]
          end
        end
      endcase
    end
  end

endmodule

// ==== sim/psr_link_checker.sv ====
// Purpose: timing checks on the three-wire link between host and sensor
// Assumes: sclk is made from MCLK, so every link signal is sampled on MCLK
// Notes: the conversion wait is recognised by how long sclk has rested low

`timescale 1ns/10ps

module psr_link_checker #(
  parameter int HALF_DIV = 2,
  parameter int BRIDGE_CYC = 20
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // serial link
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  // analogue control
  input wire logic BRIDGE_EN
);
  // ==========================================================
  // helper counters
  int hi_cnt_q;
  int lo_cnt_q;
  int one_rises_q;
  int br_cnt_q;
  logic sclk_q;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) hi_cnt_q <= 0;
    else hi_cnt_q <= sclk ? hi_cnt_q + 1 : 0;
  end

  // a fresh start counts as a full rest, so the first rise is not flagged
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) lo_cnt_q <= HALF_DIV;
    else lo_cnt_q <= sclk ? 0 : lo_cnt_q + 1;
  end

  // rises seen while dout stays high; ack plus the two spare clocks
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) one_rises_q <= 0;
    else one_rises_q <= !dout ? 0 : one_rises_q + int'(sclk && !sclk_q);
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) br_cnt_q <= 0;
    else br_cnt_q <= BRIDGE_EN ? br_cnt_q + 1 : 0;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  din_change_low_a: assert property ($changed(din) |-> !sclk)
    else $error("din moved while sclk was high");
  dout_on_rise_a: assert property ($changed(dout) |-> $rose(sclk) || (!sclk && !$past(sclk)))
    else $error("dout moved away from a sclk rise");
  sclk_high_len_a: assert property ($fell(sclk) |-> hi_cnt_q == HALF_DIV)
    else $error("sclk high phase has the wrong length");
  sclk_low_len_a: assert property ($rose(sclk) |-> lo_cnt_q >= HALF_DIV)
    else $error("sclk low phase too short");
  ack_then_two_a: assert property (!sclk && dout && lo_cnt_q == 2 * HALF_DIV + 1 |-> one_rises_q == 3)
    else $error("wait began without ack and two clocks");
  hold_until_end_a: assert property ($rose(sclk) && lo_cnt_q > 2 * HALF_DIV |-> !$past(dout))
    else $error("sclk resumed while conversion busy");
  read_after_end_a: assert property ($fell(dout) && !sclk && !$past(sclk) |-> ##[1:40] $rose(sclk))
    else $error("readout did not follow end of conversion");
  bridge_brief_a: assert property ($fell(BRIDGE_EN) |-> br_cnt_q == BRIDGE_CYC)
    else $error("bridge on time is wrong");
  bridge_in_busy_a: assert property ($rose(BRIDGE_EN) |-> dout)
    else $error("bridge powered outside a conversion");
endmodule

// ==== sim/psr_bench.sv ====
// Purpose: host and sensor joined on one link, plus a sensor driven bit by bit
// Assumes: short conversion and bridge counts, sclk divider of 3
// Notes: the second link lets the bench abort frames and stall readout

`timescale 1ns/10ps

module psr_bench;
  import psr_pkg::*;

  // ==========================================================
  // settings and signals
  localparam int CONV = 200;
  localparam int BRIDGE = 20;
  // the host's dout sync costs two clocks before its sampling fall, so two is too short
  localparam int HALF = 3;
  localparam int LIMIT = 4000;

  logic mclk;
  logic rst_b;
  logic ce;
  logic cmd_valid;
  logic cmd_ready;
  logic res_valid;
  psr_cmd_e cmd;
  logic [WORD_W-1:0] res_data;
  logic [WORD_W-1:0] press_raw;
  logic [WORD_W-1:0] temp_raw;
  logic [COEF_ONE_W-1:0] coef_one;
  logic [COEF_TWO_W-1:0] coef_two;
  logic [COEF_THREE_W-1:0] coef_three;
  logic [COEF_FOUR_W-1:0] coef_four;
  logic [COEF_FIVE_W-1:0] coef_five;
  logic [COEF_SIX_W-1:0] coef_six;
  logic bridge_en;
  logic adc_temp_sel;
  logic o_bit;
  logic [WORD_W-1:0] cal_exp [4];
  psr_cmd_e cal_cmd [4];
  int num_errors;
  int samples_checked;

  psr_link_if l1 ();
  psr_link_if l2 ();

  psr_host #(.HALF_DIV(HALF)) u_psr_host (
    .MCLK(mclk), .RST_B(rst_b), .CE(ce), .LINK(l1),
    .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready),
    .RES_VALID(res_valid), .RES_DATA(res_data)
  );

  psr_dev #(.CONV_CYC(CONV), .BRIDGE_CYC(BRIDGE)) u_psr_dev (
    .MCLK(mclk), .RST_B(rst_b), .CE(ce), .LINK(l1),
    .PRESSURE_RAW(press_raw), .TEMPERATURE_RAW(temp_raw),
    .COEF_ONE(coef_one), .COEF_TWO(coef_two), .COEF_THREE(coef_three),
    .COEF_FOUR(coef_four), .COEF_FIVE(coef_five), .COEF_SIX(coef_six),
    .BRIDGE_EN(bridge_en), .ADC_TEMP_SEL(adc_temp_sel)
  );

  psr_dev #(.CONV_CYC(CONV), .BRIDGE_CYC(BRIDGE)) u_psr_dev_2 (
    .MCLK(mclk), .RST_B(rst_b), .CE(ce), .LINK(l2),
    .PRESSURE_RAW(press_raw), .TEMPERATURE_RAW(temp_raw),
    .COEF_ONE(coef_one), .COEF_TWO(coef_two), .COEF_THREE(coef_three),
    .COEF_FOUR(coef_four), .COEF_FIVE(coef_five), .COEF_SIX(coef_six),
    .BRIDGE_EN(), .ADC_TEMP_SEL()
  );

  psr_link_checker #(.HALF_DIV(HALF), .BRIDGE_CYC(BRIDGE)) u_psr_link_checker (
    .MCLK(mclk), .RST_B(rst_b), .sclk(l1.sclk), .din(l1.din), .dout(l1.dout), .BRIDGE_EN(bridge_en)
  );

  // ==========================================================
  // tasks
  task automatic cmp(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic host_cmd(input psr_cmd_e c, input logic [WORD_W-1:0] exp);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    while (cmd_ready !== 1'b1 && n < LIMIT) begin
      @(negedge mclk);
      n++;
    end
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    if (c == CMD_RESET) begin
      while (cmd_ready === 1'b1 && n < 8) begin
        @(negedge mclk);
        n++;
      end
      while (cmd_ready !== 1'b1 && n < LIMIT) begin
        @(negedge mclk);
        got = got | res_valid;
        n++;
      end
      cmp("ready after reset", {15'h0, cmd_ready}, 16'h1);
      cmp("no word after reset", {15'h0, got}, 16'h0);
    end else begin
      while (res_valid !== 1'b1 && n < LIMIT) begin
        @(negedge mclk);
        n++;
      end
      cmp("result flag", {15'h0, res_valid}, 16'h1);
      cmp("result word", res_data, exp);
    end
  endtask

  // one 30 ns sclk period as the far host, free of MCLK phase; din moves with the fall
  task automatic bit2(input logic b, output logic o);
    l2.din = b;
    #15;
    l2.sclk = 1'b1;
    #15;
    o = l2.dout;
    l2.sclk = 1'b0;
  endtask

  task automatic send2(input logic [RESET_LEN-1:0] bits, input int len, output logic o);
    for (int i = len - 1; i >= 0; i--) begin
      bit2(bits[i], o);
    end
  endtask

  task automatic frame2(input logic [SETUP_LEN-1:0] setup, input logic [STOP_LEN-1:0] stop, output logic o);
    send2({11'h0, 3'b111, setup, stop}, CMD_LEN, o);
  endtask

  task automatic read2(input logic [WORD_W-1:0] exp, input int pause);
    logic [WORD_W-1:0] w;
    logic o;
    w = '0;
    for (int k = 0; k < WORD_W; k++) begin
      bit2(1'b0, o);
      w = {w[WORD_W-2:0], o};
      if (k == pause) repeat (40) @(negedge mclk);
    end
    cmp("word on second link", w, exp);
    bit2(1'b0, o);
    cmp("line after last bit", {15'h0, o}, 16'h0);
  endtask

  task automatic conv2(input logic [SETUP_LEN-1:0] setup, input logic [WORD_W-1:0] exp);
    logic o;
    int n;
    frame2(setup, 3'b000, o);
    cmp("conversion ack", {15'h0, o}, 16'h1);
    bit2(1'b0, o);
    bit2(1'b0, o);
    cmp("busy through spare clocks", {15'h0, o}, 16'h1);
    n = 0;
    while (l2.dout !== 1'b0 && n < LIMIT) begin
      @(negedge mclk);
      n++;
    end
    cmp("end of conversion", {15'h0, l2.dout}, 16'h0);
    read2(exp, 4);
  endtask

  // ==========================================================
  // clock, watchdog and tests
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // the whole run needs well under a tenth of this
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    $display("[FAIL] run length expected finish seen hang");
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd = CMD_PRESS;
    press_raw = 16'hB36D;
    temp_raw = 16'h4C92;
    coef_one = 13'h1ABC;
    coef_two = 13'h0F0F;
    coef_three = 9'h1A5;
    coef_four = 9'h0C3;
    coef_five = 12'hB7E;
    coef_six = 8'h96;
    l2.sclk = 1'b0;
    l2.din = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    cal_cmd = '{CMD_CAL1, CMD_CAL2, CMD_CAL3, CMD_CAL4};
    cal_exp[0] = {coef_three[7:0], coef_five[7:0]};
    cal_exp[1] = {coef_four[7:0], coef_six};
    cal_exp[2] = {coef_five[11:8], coef_one[11:0]};
    cal_exp[3] = {coef_one[12], coef_four[8], coef_three[8], coef_two[12:0]};
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_cmd(cal_cmd[i], cal_exp[i]);
    end
    $display("test calibration words done");
    host_cmd(CMD_PRESS, press_raw);
    cmp("converter select", {15'h0, adc_temp_sel}, 16'h0);
    host_cmd(CMD_TEMP, temp_raw);
    cmp("converter select", {15'h0, adc_temp_sel}, 16'h1);
    press_raw = 16'hFFFF;
    host_cmd(CMD_PRESS, 16'hFFFF);
    host_cmd(CMD_RESET, 16'h0);
    host_cmd(CMD_CAL4, cal_exp[3]);
    $display("test host conversions done");
    send2(RESET_PATTERN, RESET_LEN, o_bit);
    send2(21'h1D, 5, o_bit);
    send2(RESET_PATTERN, RESET_LEN, o_bit);
    cmp("line after restart", {15'h0, l2.dout}, 16'h0);
    frame2(SETUP_CAL2, 3'b000, o_bit);
    cmp("no ack for calibration", {15'h0, o_bit}, 16'h0);
    read2(cal_exp[1], 7);
    frame2(SETUP_CAL1, 3'b001, o_bit);
    read2(16'h0, 3);
    conv2(SETUP_PRESS, press_raw);
    conv2(SETUP_TEMP, temp_raw);
    $display("test second link done");
    report_and_stop();
  end
endmodule
